/* File: src/wst_pkg.sv */
/*
  Shared constants and types for the waveform sampling and temperature
  select block. Assumes a single 125 MHz clock and a synchronous reset.
*/
package wst_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_STATUS = 16'he502;
  localparam logic [15:0] ADDR_MASK = 16'he50a;
  localparam logic [15:0] ADDR_CONFIG = 16'he618;
  localparam logic [15:0] ADDR_THIRD_CONFIGURATION = 16'he708;
  // Groups of four, index in addr[1:0]: 0=A 1=B 2=C 3=N
  localparam logic [15:0] BASE_CUR_SAMPLE = 16'he800;
  localparam logic [15:0] BASE_TEMP_OFFSET = 16'he804;
  localparam logic [15:0] BASE_TEMP_GAIN = 16'he808;
  localparam logic [15:0] BASE_TEMP_RESULT = 16'he80c;
  localparam logic [15:0] BASE_V2_SAMPLE = 16'he810;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int READY_FLAG_BIT = 17;
  localparam int HPF_EN_BIT = 4;
  localparam logic [1:0] PIN_FN_READY = 2'h0;
  localparam logic [15:0] CONFIG_RESET = 16'h0010;
  localparam logic [7:0] THIRD_CONFIGURATION_RESET = 8'h0f;
  localparam int OFFSET_SHIFT = 11;
  localparam int GAIN_FRAC_BITS = 23;
  localparam int HPF_SHIFT = 10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SAMPLE_RATE_HZ = 8000;
  localparam int unsigned SAMPLE_DIV_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int unsigned READY_DELAY_NS = 70;
  localparam int unsigned READY_DELAY_CYC = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READY_LOW_NS = 10000;
  localparam int unsigned READY_LOW_CYC = READY_LOW_NS / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_MS = 1024;
  localparam int unsigned SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0][23:0] cur;
    logic [3:0][23:0] third;
  } wst_conv_set_t;

  typedef struct packed {
    logic valid;
    logic [1:0] phase;
    logic [7:0] value;
  } wst_offset_msg_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [15:0] addr;
    logic [31:0] wdata;
  } wst_reg_req_t;

  typedef enum logic [1:0] {
    RDY_IDLE = 2'b00,
    RDY_WAIT = 2'b01,
    RDY_LOW = 2'b10
  } wst_rdy_state_t;

endpackage : wst_pkg

/* File: src/wst_top.sv */
/*
  Waveform sample capture, high-pass filtering, ready signalling and
  per-phase temperature select with offset, gain and result registers.
  Assumes converter sets and offset messages come from same-clock logic
  and that the serial port front end presents plain register requests.
*/
`timescale 1ns/1ps

module wst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;

  assign in_ready = (count_r != (AW + 1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wptr_nxt = push ? ((wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1) : wptr_r;
    rptr_nxt = pop ? ((rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1) : rptr_r;
    count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end
endmodule : wst_fifo

module wst_top #(
  parameter int unsigned SAMPLE_DIV = wst_pkg::SAMPLE_DIV_CYC,
  parameter int unsigned SETTLE = wst_pkg::SETTLE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conv_valid,
  input wire wst_pkg::wst_conv_set_t conv_set,
  output logic conv_ready,
  input wire wst_pkg::wst_offset_msg_t offset_msg,
  input wire wst_pkg::wst_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic crossing_or_ready_pin,
  output logic irq_n,
  output logic phase_a_sensor_select_pin,
  output logic phase_b_sensor_select_pin,
  output logic phase_c_sensor_select_pin,
  output logic neutral_sensor_select_pin,
  output logic [3:0] temp_comp_active
);
  import wst_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [23:0] sat24(input logic [33:0] v);
    if ($signed(v) > $signed(34'h00_007f_ffff)) begin
      return 24'h7fffff;
    end else if ($signed(v) < -$signed(34'h00_0080_0000)) begin
      return 24'h800000;
    end
    return v[23:0];
  endfunction : sat24

  function automatic logic [23:0] hpf_out(input logic [23:0] x, input logic [33:0] acc);
    logic [33:0] diff;
    diff = {{10{x[23]}}, x} - {{10{acc[33]}}, acc[33:HPF_SHIFT]};
    return sat24(diff);
  endfunction : hpf_out

  function automatic logic [23:0] temp_scale(input logic [23:0] code, input logic [7:0] off,
                                             input logic [23:0] gain);
    logic signed [31:0] sum;
    logic signed [24:0] mult;
    logic signed [56:0] prod;
    sum = $signed({{8{code[23]}}, code}) + ($signed({{24{off[7]}}, off}) <<< OFFSET_SHIFT);
    mult = $signed(25'h0800000) + $signed({gain[23], gain});
    prod = sum * mult;
    return sat24(prod[56:GAIN_FRAC_BITS]);
  endfunction : temp_scale

  // ----------------------------------------------------------------
  // Sample rate divider and input FIFO
  // ----------------------------------------------------------------
  logic [13:0] div_r, div_nxt;
  logic tick, pop, fifo_valid;
  wst_conv_set_t fifo_data;

  always_comb begin
    div_nxt = (div_r == 14'(SAMPLE_DIV - 1)) ? '0 : div_r + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign tick = (div_r == 14'(SAMPLE_DIV - 1));
  assign pop = tick && fifo_valid;

  wst_fifo #(.WIDTH($bits(wst_conv_set_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data(conv_set),
    .out_valid(fifo_valid),
    .out_ready(tick),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic flag_r, flag_nxt, mask_r, mask_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [7:0] cfg3_r, cfg3_nxt;
  logic [3:0][23:0] cur_r, cur_nxt, v2_r, v2_nxt, temp_r, temp_nxt, gain_r, gain_nxt;
  logic [3:0][7:0] off_r, off_nxt;
  logic [7:0][33:0] acc_r, acc_nxt;
  logic [3:0][26:0] cnt_r, cnt_nxt;
  logic [3:0] settled_r, settled_nxt;
  logic [31:0] rdata_nxt;
  logic wr, clr;
  logic [1:0] idx;
  logic [13:0] grp;

  assign wr = reg_req.wr_en;
  assign idx = reg_req.addr[1:0];
  assign grp = reg_req.addr[15:2];
  assign clr = wr && (reg_req.addr == ADDR_STATUS) && reg_req.wdata[READY_FLAG_BIT];

  always_comb begin
    cfg_nxt = cfg_r;
    cfg3_nxt = cfg3_r;
    mask_nxt = mask_r;
    gain_nxt = gain_r;
    off_nxt = off_r;
    cur_nxt = cur_r;
    v2_nxt = v2_r;
    temp_nxt = temp_r;
    acc_nxt = acc_r;
    if (wr && reg_req.addr == ADDR_CONFIG) cfg_nxt = reg_req.wdata[15:0];
    if (wr && reg_req.addr == ADDR_THIRD_CONFIGURATION) cfg3_nxt = reg_req.wdata[7:0];
    if (wr && reg_req.addr == ADDR_MASK) mask_nxt = reg_req.wdata[READY_FLAG_BIT];
    if (wr && grp == BASE_TEMP_GAIN[15:2]) gain_nxt[idx] = reg_req.wdata[23:0];
    if (offset_msg.valid) off_nxt[offset_msg.phase] = offset_msg.value;
    for (int i = 0; i < 4; i++) begin
      cnt_nxt[i] = cfg3_r[i] ? '0 : ((cnt_r[i] == 27'(SETTLE)) ? cnt_r[i] : cnt_r[i] + 1'b1);
      settled_nxt[i] = (cnt_nxt[i] == 27'(SETTLE));
      if (pop) begin
        if (cfg_r[HPF_EN_BIT]) begin
          cur_nxt[i] = hpf_out(fifo_data.cur[i], acc_r[i]);
          acc_nxt[i] = acc_r[i] + {{10{cur_nxt[i][23]}}, cur_nxt[i]};
        end else begin
          cur_nxt[i] = fifo_data.cur[i];
        end
        // front end routes by select pin
        if (cfg3_r[i]) begin
          if (cfg_r[HPF_EN_BIT]) begin
            v2_nxt[i] = hpf_out(fifo_data.third[i], acc_r[4 + i]);
            acc_nxt[4 + i] = acc_r[4 + i] + {{10{v2_nxt[i][23]}}, v2_nxt[i]};
          end else begin
            v2_nxt[i] = fifo_data.third[i];
          end
        end else if (settled_r[i]) begin
          temp_nxt[i] = temp_scale(fifo_data.third[i], off_r[i], gain_r[i]);
        end
      end
    end
    flag_nxt = (flag_r && !clr) || pop;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_r <= CONFIG_RESET;
      cfg3_r <= THIRD_CONFIGURATION_RESET;
      mask_r <= 1'b0;
      flag_r <= 1'b0;
      gain_r <= '0;
      off_r <= '0;
      cur_r <= '0;
      v2_r <= '0;
      temp_r <= '0;
      acc_r <= '0;
      cnt_r <= '0;
      settled_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      cfg3_r <= cfg3_nxt;
      mask_r <= mask_nxt;
      flag_r <= flag_nxt;
      gain_r <= gain_nxt;
      off_r <= off_nxt;
      cur_r <= cur_nxt;
      v2_r <= v2_nxt;
      temp_r <= temp_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      settled_r <= settled_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (reg_req.addr == ADDR_STATUS) rdata_nxt[READY_FLAG_BIT] = flag_r;
    if (reg_req.addr == ADDR_MASK) rdata_nxt[READY_FLAG_BIT] = mask_r;
    if (reg_req.addr == ADDR_CONFIG) rdata_nxt = {16'h0000, cfg_r};
    if (reg_req.addr == ADDR_THIRD_CONFIGURATION) rdata_nxt = {24'h000000, cfg3_r};
    if (grp == BASE_CUR_SAMPLE[15:2]) rdata_nxt = {{8{cur_r[idx][23]}}, cur_r[idx]};
    if (grp == BASE_V2_SAMPLE[15:2]) rdata_nxt = {{8{v2_r[idx][23]}}, v2_r[idx]};
    if (grp == BASE_TEMP_OFFSET[15:2]) rdata_nxt = {{24{off_r[idx][7]}}, off_r[idx]};
    if (grp == BASE_TEMP_GAIN[15:2]) rdata_nxt = {{8{gain_r[idx][23]}}, gain_r[idx]};
    if (grp == BASE_TEMP_RESULT[15:2]) rdata_nxt = {8'h00, temp_r[idx]};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_req.rd_en ? rdata_nxt : reg_rdata;
      reg_rvalid <= reg_req.rd_en;
    end
  end

  // ----------------------------------------------------------------
  // Ready pulse
  // ----------------------------------------------------------------
  wst_rdy_state_t rdy_r, rdy_nxt;
  logic [10:0] rcnt_r, rcnt_nxt;

  always_comb begin
    rdy_nxt = rdy_r;
    rcnt_nxt = rcnt_r + 1'b1;
    unique case (rdy_r)
      RDY_IDLE: begin
        rcnt_nxt = '0;
        if (pop && cfg_r[1:0] == PIN_FN_READY) rdy_nxt = RDY_WAIT;
      end
      RDY_WAIT: begin
        if (rcnt_r == 11'(READY_DELAY_CYC - 1)) begin
          rdy_nxt = RDY_LOW;
          rcnt_nxt = '0;
        end
      end
      RDY_LOW: begin
        if (rcnt_r == 11'(READY_LOW_CYC - 1)) rdy_nxt = RDY_IDLE;
      end
      default: begin
        rdy_nxt = RDY_IDLE;
        rcnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdy_r <= RDY_IDLE;
      rcnt_r <= '0;
    end else begin
      rdy_r <= rdy_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end

  assign crossing_or_ready_pin = (rdy_r != RDY_LOW);
  assign irq_n = !(flag_r && mask_r);
  assign phase_a_sensor_select_pin = cfg3_r[0];
  assign phase_b_sensor_select_pin = cfg3_r[1];
  assign phase_c_sensor_select_pin = cfg3_r[2];
  assign neutral_sensor_select_pin = cfg3_r[3];
  assign temp_comp_active = settled_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [10:0] low_len_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_len_r <= '0;
    end else begin
      low_len_r <= crossing_or_ready_pin ? '0 : low_len_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_ready_wait;
    ##1 crossing_or_ready_pin [*8] ##1 crossing_or_ready_pin ##1 !crossing_or_ready_pin;
  endsequence

  bypass_path_a: assert property (pop && !cfg_r[HPF_EN_BIT] |=>
    cur_r[0] == $past(fifo_data.cur[0])) else $error("bypass sample mismatch");
  flag_set_a: assert property (pop |=> flag_r) else $error("ready flag not set");
  irq_gate_a: assert property (pop && mask_r && !(wr && reg_req.addr == ADDR_MASK)
    |=> !irq_n) else $error("irq missing");
  ready_delay_a: assert property (pop && rdy_r == RDY_IDLE && cfg_r[1:0] == 2'h0
    |-> s_ready_wait) else $error("ready pin delay wrong");
  ready_width_a: assert property ($rose(crossing_or_ready_pin) |->
    low_len_r == 11'(READY_LOW_CYC)) else $error("ready pulse width wrong");
  sample_sext_a: assert property (reg_req.rd_en && grp == BASE_CUR_SAMPLE[15:2] |=>
    reg_rdata[31:24] == {8{reg_rdata[23]}}) else $error("sample not sign extended");
  select_pin_a: assert property (wr && reg_req.addr == ADDR_THIRD_CONFIGURATION |=>
    phase_a_sensor_select_pin == $past(reg_req.wdata[0])) else $error("select pin wrong");
  offset_store_a: assert property (offset_msg.valid && offset_msg.phase == 2'h0 |=>
    off_r[0] == $past(offset_msg.value)) else $error("offset not stored");
  temp_hold_a: assert property (!settled_r[0] |=> $stable(temp_r[0]))
    else $error("temperature written early");
  temp_pad_a: assert property (reg_req.rd_en && grp == BASE_TEMP_RESULT[15:2] |=>
    reg_rdata[31:24] == 8'h00) else $error("temperature not zero padded");
  comp_active_a: assert property (cfg3_r[0] |=> !temp_comp_active[0])
    else $error("compensation active in voltage mode");
  flag_clear_a: assert property (clr && !pop && flag_r |=> !flag_r)
    else $error("flag not cleared");
endmodule : wst_top

/* File: tb/wst_host_model.sv */
/*
  Host controller model: plain register reads and writes on the request port.
  Assumes one shared clock; the testbench calls its tasks by hierarchy.
*/
`timescale 1ns/1ps

module wst_host_model
  import wst_pkg::*;
(
  input wire logic clk,
  output wst_pkg::wst_reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  initial begin
    reg_req = '0;
  end

  function automatic real to_celsius(input logic [23:0] code);
    return 8.72101e-5 * real'(code) - 306.47;
  endfunction : to_celsius

  // Idle fields show the inverse so stale values never look valid
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk);
    #1;
    reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    #1;
    reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 32'hffffffff};
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : wst_host_model

/* File: tb/waveform_sampling_temp_select_tb_top.sv */
/*
  Self-checking bench for the waveform sampling and temperature select block.
  Assumes shortened sample and settle counts; the host model drives registers.
*/
`timescale 1ns/1ps

module waveform_sampling_temp_select_tb_top;
  import wst_pkg::*;
  localparam int unsigned DIV = 1400;
  localparam int unsigned SET = 50;
  logic clk, reset_n, conv_valid, conv_ready, reg_rvalid, pin, irq_n, ok;
  wst_conv_set_t conv_set;
  wst_offset_msg_t offset_msg;
  wst_reg_req_t reg_req;
  logic [31:0] reg_rdata, rd_v;
  logic [3:0] sel, comp;
  int miscompares, checks_done;

  wst_top #(.SAMPLE_DIV(DIV), .SETTLE(SET)) wst_top_inst (
    .clk(clk), .reset_n(reset_n), .conv_valid(conv_valid), .conv_set(conv_set),
    .conv_ready(conv_ready), .offset_msg(offset_msg), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .crossing_or_ready_pin(pin),
    .irq_n(irq_n), .phase_a_sensor_select_pin(sel[0]), .phase_b_sensor_select_pin(sel[1]),
    .phase_c_sensor_select_pin(sel[2]), .neutral_sensor_select_pin(sel[3]),
    .temp_comp_active(comp)
  );

  wst_host_model wst_host_model_inst (
    .clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rdc(input string what, input logic [15:0] a, input logic [31:0] exp);
    wst_host_model_inst.rd(a, rd_v, ok);
    chk("read valid", 32'h1, {31'h0, ok});
    chk(what, exp, rd_v);
  endtask : rdc

  task automatic push(input logic [23:0] cur_a, input logic [23:0] v2, input logic [23:0] tc);
    wst_conv_set_t c;
    c = '0;
    c.cur[0] = cur_a;
    c.third[0] = sel[0] ? v2 : tc;
    @(posedge clk);
    #1;
    conv_valid = 1'b1;
    conv_set = c;
    @(posedge clk);
    #1;
    conv_valid = 1'b0;
    conv_set = ~c;
  endtask : push

  // Waits for one ready pulse and returns after its rising edge
  task automatic wait_pulse();
    int n;
    n = 0;
    while (pin !== 1'b0 && n < 2 * DIV) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready pin low", 32'h0, {31'h0, pin});
    n = 0;
    while (pin === 1'b0 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready low cycles", READY_LOW_CYC, n);
  endtask : wait_pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc("config reset", ADDR_CONFIG, 32'h00000010);
    rdc("third_configuration reset", ADDR_THIRD_CONFIGURATION, 32'h0000000f);
    chk("select pins reset", 32'hf, {28'h0, sel});
    chk("irq idle", 32'h1, {31'h0, irq_n});
    rdc("status reset", ADDR_STATUS, 32'h0);
    rdc("unmapped read", 16'he900, 32'h0);
    wst_host_model_inst.wr(BASE_CUR_SAMPLE, 32'h00123456);
    rdc("read-only write", BASE_CUR_SAMPLE, 32'h0);
  endtask : t_reset

  task automatic t_hpf();
    push(24'h100000, 24'h0, 24'h0);
    wait_pulse();
    rdc("first filtered", BASE_CUR_SAMPLE, 32'h00100000);
    push(24'h100000, 24'h0, 24'h0);
    wait_pulse();
    rdc("dc removed", BASE_CUR_SAMPLE, 32'h000ffc00);
    wst_host_model_inst.wr(ADDR_STATUS, 32'h00020000);
  endtask : t_hpf

  task automatic t_capture();
    wst_host_model_inst.wr(ADDR_CONFIG, 32'h0);
    push(24'h800001, 24'h400000, 24'h0);
    wait_pulse();
    rdc("current sample", BASE_CUR_SAMPLE, 32'hff800001);
    rdc("voltage sample", BASE_V2_SAMPLE, 32'h00400000);
    rdc("ready flag", ADDR_STATUS, 32'h00020000);
    chk("irq masked", 32'h1, {31'h0, irq_n});
    wst_host_model_inst.wr(ADDR_MASK, 32'h00020000);
    chk("irq enabled", 32'h0, {31'h0, irq_n});
    wst_host_model_inst.wr(ADDR_STATUS, 32'h00020000);
    chk("irq cleared", 32'h1, {31'h0, irq_n});
    rdc("flag cleared", ADDR_STATUS, 32'h0);
  endtask : t_capture

  task automatic t_pin_function();
    int lows;
    lows = 0;
    wst_host_model_inst.wr(ADDR_CONFIG, 32'h00000001);
    push(24'h000005, 24'h0, 24'h0);
    repeat (2 * DIV) begin
      @(posedge clk);
      #1;
      if (pin !== 1'b1) lows++;
    end
    chk("pin held in crossing mode", 32'h0, lows);
    rdc("flag in crossing mode", ADDR_STATUS, 32'h00020000);
    wst_host_model_inst.wr(ADDR_STATUS, 32'h00020000);
    wst_host_model_inst.wr(ADDR_CONFIG, 32'h0);
  endtask : t_pin_function

  task automatic t_temperature();
    int n;
    @(posedge clk);
    #1;
    offset_msg = '{valid: 1'b1, phase: 2'h0, value: 8'hff};
    @(posedge clk);
    #1;
    offset_msg = '{valid: 1'b0, phase: 2'h3, value: 8'h00};
    rdc("temp offset", BASE_TEMP_OFFSET, 32'hffffffff);
    wst_host_model_inst.wr(BASE_TEMP_GAIN, 32'h00400000);
    rdc("temp gain", BASE_TEMP_GAIN, 32'h00400000);
    wst_host_model_inst.wr(ADDR_THIRD_CONFIGURATION, 32'h0000000e);
    chk("select a low", 32'he, {28'h0, sel});
    chk("not yet settled", 32'h0, {28'h0, comp});
    n = 0;
    while (comp !== 4'h1 && n < SET + 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("compensation active", 32'h1, {28'h0, comp});
    push(24'h0, 24'h0, 24'hf00000);
    wait_pulse();
    rdc("temp result", BASE_TEMP_RESULT, 32'h00e7f400);
    chk("temp celsius", 32'd1019, int'(wst_host_model_inst.to_celsius(rd_v[23:0])));
    wst_host_model_inst.wr(ADDR_THIRD_CONFIGURATION, 32'h0000000f);
    chk("select a high", 32'hf, {28'h0, sel});
  endtask : t_temperature

  task automatic t_fifo();
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      push(24'(k), 24'h0, 24'h0);
    end
    chk("fifo full", 32'h0, {31'h0, conv_ready});
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      wait_pulse();
      rdc("queued sample", BASE_CUR_SAMPLE, 32'(k));
    end
    chk("fifo drained", 32'h1, {31'h0, conv_ready});
  endtask : t_fifo

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    reset_n = 1'b0;
    conv_valid = 1'b0;
    conv_set = '0;
    offset_msg = '0;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_hpf();
    t_capture();
    t_pin_function();
    t_temperature();
    t_fifo();
    print_verdict();
  end
endmodule : waveform_sampling_temp_select_tb_top
